// *** fhp_params.svh ***
// constants of the floppy host port: opcodes, octal error codes, timing
// assumes inclusion by fhp_pkg and the design modules
`ifndef FHP_PARAMS_SVH
`define FHP_PARAMS_SVH
// io transfer instruction layout
`define FHP_IOT_OPC 3'h6
`define FHP_OPC_MSB 11
`define FHP_OPC_LSB 9
`define FHP_SEL_MSB 8
`define FHP_SEL_LSB 3
`define FHP_DEV_CODE_RST 6'h38
// operation codes in the low three bits
`define FHP_OP_LCMD 3'h1
`define FHP_OP_XFER 3'h2
`define FHP_OP_TTR 3'h3
`define FHP_OP_TERR 3'h4
`define FHP_OP_TDONE 3'h5
`define FHP_OP_INTEN 3'h6
`define FHP_OP_INIT 3'h7
// function codes seen at function end
`define FHP_FN_RD_STAT 3'h5
`define FHP_FN_RD_ERR 3'h7
// error codes, octal 0010 .. 0210
`define FHP_CODE_HOME0 12'h008
`define FHP_CODE_HOME1 12'h010
`define FHP_CODE_HOME_OUT 12'h018
`define FHP_CODE_TRK_HI 12'h020
`define FHP_CODE_HOME_EARLY 12'h028
`define FHP_CODE_DIAG 12'h030
`define FHP_CODE_SECT_MISS 12'h038
`define FHP_CODE_NO_CLK 12'h048
`define FHP_CODE_NO_PRE 12'h050
`define FHP_CODE_NO_MARK 12'h058
`define FHP_CODE_HDR_CRC 12'h060
`define FHP_CODE_TRK_MIS 12'h068
`define FHP_CODE_ID_TRIES 12'h070
`define FHP_CODE_DAM_MISS 12'h078
`define FHP_CODE_DATA_CRC 12'h080
`define FHP_CODE_PARITY 12'h088
`define FHP_CODE_NONE 12'h000
// limits
`define FHP_TRACK_MAX 7'h4D
`define FHP_HDR_LIMIT 6'h34
// timing
`define FHP_CLK_NS 8
`define FHP_SEP_GAP_NS 40000
`define FHP_SEP_GAP_CYC (`FHP_SEP_GAP_NS / `FHP_CLK_NS)
`endif

// *** fhp_pkg.sv ***
// types of the floppy host port
// assumes fhp_params.svh beside it
`include "fhp_params.svh"
package fhp_pkg;
    typedef enum logic [1:0] {
        FHP_ST_IDLE = 2'b00,
        FHP_ST_ARMED = 2'b01,
        FHP_ST_DONE = 2'b10
    } fhp_iot_state_type;

    typedef struct packed {
        logic home0; logic home1; logic home_out; logic trk_hi;
        logic home_early; logic diag; logic sect_miss; logic no_clk;
        logic no_pre; logic no_mark; logic hdr_crc; logic trk_mis;
        logic id_tries; logic dam_miss; logic data_crc; logic parity;
    } fhp_err_ev_type;

    typedef struct packed {
        logic tr;
        logic done;
        logic err;
    } fhp_flags_type;

    typedef struct packed {
        logic io_pause_n;
        logic tp3;
        logic tp4;
        logic init;
        logic sep_clk;
        logic [11:0] md;
        logic [11:0] dbus;
    } fhp_pins_type;

    typedef struct packed {
        logic [11:0] code_r;
    } fhp_hold_state_type;
endpackage

// *** fhp_err_hold.sv ***
// error code holder: turns error events into one octal code
// assumes events are one-cycle pulses on the core clock
`timescale 1ns/100ps
`default_nettype none
`include "fhp_params.svh"
module fhp_err_hold (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // events and clear
    input wire fhp_pkg::fhp_err_ev_type i_ev,
    input wire logic i_clr,
    // held code
    output logic [11:0] o_code
);
    import fhp_pkg::*;

    fhp_hold_state_type r, n;

    function automatic logic [11:0] fhp_encode(input fhp_err_ev_type e);
        logic [11:0] c;
        c = `FHP_CODE_NONE;
        if (e.dam_miss) c = `FHP_CODE_DAM_MISS;
        if (e.id_tries) c = `FHP_CODE_ID_TRIES;
        if (e.trk_mis) c = `FHP_CODE_TRK_MIS;
        if (e.hdr_crc) c = `FHP_CODE_HDR_CRC;
        if (e.no_mark) c = `FHP_CODE_NO_MARK;
        if (e.no_pre) c = `FHP_CODE_NO_PRE;
        if (e.no_clk) c = `FHP_CODE_NO_CLK;
        if (e.sect_miss) c = `FHP_CODE_SECT_MISS;
        if (e.diag) c = `FHP_CODE_DIAG;
        if (e.home_early) c = `FHP_CODE_HOME_EARLY;
        if (e.trk_hi) c = `FHP_CODE_TRK_HI;
        if (e.home_out) c = `FHP_CODE_HOME_OUT;
        if (e.home1) c = `FHP_CODE_HOME1;
        if (e.home0) c = `FHP_CODE_HOME0;
        if (e.parity) c = `FHP_CODE_PARITY;
        return c;
    endfunction

    // data crc carries no code into the holder
    logic [11:0] enc;
    always_comb begin
        n = r;
        enc = fhp_encode(i_ev);
        if (i_clr) begin
            n.code_r = `FHP_CODE_NONE;
        end
        if (enc != `FHP_CODE_NONE) begin
            n.code_r = enc;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_code = r.code_r;

    parity_code_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_ev.parity |=> o_code == `FHP_CODE_PARITY)
        else $error("parity event did not leave its code");
    crc_keeps_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ev == 16'h0002) && !i_clr |=> $stable(o_code))
        else $error("data crc changed the held code");
endmodule
`default_nettype wire

// *** fhp_host_port.sv ***
// programmed-io host port of the floppy subsystem, device side
// assumes bus pins are asynchronous and controller signals share the core clock
`timescale 1ns/100ps
`default_nettype none
`include "fhp_params.svh"
module fhp_host_port #(
    parameter int unsigned SEP_GAP_CYC = `FHP_SEP_GAP_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // backplane pins
    input wire fhp_pkg::fhp_pins_type i_pins,
    output logic [11:0] o_dbus_out,
    output logic o_dbus_oe,
    output logic o_internal_io_oe,
    output logic o_skip_oe,
    output logic o_service_request_oe,
    output logic o_transfer_control_a_oe,
    output logic o_transfer_control_b_oe,
    // configuration
    input wire logic [5:0] i_dev_code,
    // controller side
    input wire logic i_ctl_dir_out,
    input wire logic i_tr_set,
    input wire logic i_err_set,
    input wire logic i_xfer_load,
    input wire logic [11:0] i_xfer_word,
    input wire logic i_func_end,
    input wire logic [2:0] i_func,
    input wire logic [11:0] i_error_status_word,
    input wire fhp_pkg::fhp_err_ev_type i_err_ev,
    input wire logic i_reading,
    input wire logic i_hdr_seen,
    input wire logic i_hdr_match,
    input wire logic i_seek_start,
    input wire logic [6:0] i_want_track,
    // to controller
    output logic [11:0] o_ifr,
    output logic o_ifr_wr,
    output logic o_ctl_init,
    output logic o_int_en,
    output logic [11:0] o_err_code
);
    import fhp_pkg::*;

    typedef struct packed {
        fhp_pins_type s1;
        fhp_pins_type s2;
        logic tp3_d;
        logic tp4_d;
        logic sep_d;
        logic init_d;
        fhp_iot_state_type st;
        logic [2:0] op;
        fhp_flags_type flags;
        logic int_en;
        logic [11:0] ifr;
        logic [11:0] dout;
        logic dout_oe;
        logic iio;
        logic skip;
        logic irq;
        logic ctl_a;
        logic ctl_b;
        logic ifr_wr;
        logic ctl_init;
        logic [12:0] gap_cnt;
        logic [5:0] hdr_cnt;
        fhp_err_ev_type ev;
        logic hold_clr;
    } fhp_state_type;

    fhp_state_type r, n;
    logic [11:0] hold_code;

    function automatic logic fhp_selected(input logic [11:0] md, input logic [5:0] dev);
        return (md[`FHP_OPC_MSB:`FHP_OPC_LSB] == `FHP_IOT_OPC) &&
            (md[`FHP_SEL_MSB:`FHP_SEL_LSB] == dev);
    endfunction

    function automatic logic fhp_rise(input logic now, input logic was);
        return now & ~was;
    endfunction

    logic pause;
    logic hit;
    logic tp3_rise;
    logic tp4_rise;
    logic sep_edge;
    logic init_rise;
    logic [2:0] md_op;

    always_comb begin
        n = r;
        // two flip-flops on every pin
        n.s1 = i_pins;
        n.s2 = r.s1;
        n.tp3_d = r.s2.tp3;
        n.tp4_d = r.s2.tp4;
        n.sep_d = r.s2.sep_clk;
        n.init_d = r.s2.init;
        n.ifr_wr = 1'b0;
        n.ctl_init = 1'b0;
        n.ev = '0;
        n.hold_clr = 1'b0;
        pause = ~r.s2.io_pause_n;
        hit = pause && fhp_selected(r.s2.md, i_dev_code);
        md_op = r.s2.md[2:0];
        tp3_rise = fhp_rise(r.s2.tp3, r.tp3_d);
        tp4_rise = fhp_rise(r.s2.tp4, r.tp4_d);
        sep_edge = fhp_rise(r.s2.sep_clk, r.sep_d);
        init_rise = fhp_rise(r.s2.init, r.init_d);

        // io instruction sequencer
        case (r.st)
            FHP_ST_IDLE: begin
                if (hit) begin
                    n.st = FHP_ST_ARMED;
                    n.op = md_op;
                    n.iio = 1'b1;
                    case (md_op)
                        `FHP_OP_TTR: n.skip = r.flags.tr;
                        `FHP_OP_TDONE: n.skip = r.flags.done;
                        `FHP_OP_TERR: n.skip = r.flags.err;
                        `FHP_OP_XFER: begin
                            if (i_ctl_dir_out) begin
                                n.dout = r.ifr;
                                n.dout_oe = 1'b1;
                                n.ctl_b = 1'b1;
                            end
                        end
                        default: n.skip = 1'b0;
                    endcase
                end
            end
            FHP_ST_ARMED: begin
                if (!pause) begin
                    n.st = FHP_ST_IDLE;
                end else if (tp3_rise) begin
                    n.st = FHP_ST_DONE;
                    case (r.op)
                        `FHP_OP_TTR: n.flags.tr = 1'b0;
                        `FHP_OP_TDONE: n.flags.done = 1'b0;
                        `FHP_OP_TERR: n.flags.err = 1'b0;
                        `FHP_OP_INTEN: n.int_en = r.s2.dbus[0];
                        `FHP_OP_INIT: n.ctl_init = 1'b1;
                        default: n.skip = r.skip;
                    endcase
                end
            end
            FHP_ST_DONE: begin
                if (!pause) begin
                    n.st = FHP_ST_IDLE;
                end else if (tp4_rise) begin
                    if (r.op == `FHP_OP_LCMD ||
                        (r.op == `FHP_OP_XFER && !r.dout_oe)) begin
                        n.ifr = r.s2.dbus;
                        n.ifr_wr = 1'b1;
                    end
                end
            end
            default: n.st = FHP_ST_IDLE;
        endcase

        // pin drivers drop once the pause ends
        if (n.st == FHP_ST_IDLE) begin
            n.iio = 1'b0;
            n.skip = 1'b0;
            n.dout_oe = 1'b0;
            n.ctl_a = 1'b0;
            n.ctl_b = 1'b0;
        end

        // controller events; a set in a test's clearing cycle wins, but initialize clears flags over a set
        if (i_tr_set) begin
            n.flags.tr = 1'b1;
        end
        if (i_err_set) begin
            n.flags.err = 1'b1;
        end
        if (i_xfer_load) begin
            n.ifr = i_xfer_word;
        end
        if (i_func_end) begin
            n.flags.done = 1'b1;
            if (i_func == `FHP_FN_RD_ERR) begin
                n.ifr = hold_code;
            end else begin
                n.ifr = i_error_status_word;
            end
            if (i_func == `FHP_FN_RD_STAT) begin
                n.hold_clr = 1'b1;
            end
        end

        // bit clock watchdog while reading
        if (!i_reading || sep_edge) begin
            n.gap_cnt = '0;
        end else if (r.gap_cnt < 13'(SEP_GAP_CYC)) begin
            n.gap_cnt = r.gap_cnt + 13'h001;
        end
        n.ev.no_clk = (r.gap_cnt == 13'(SEP_GAP_CYC - 1)) && i_reading && !sep_edge;

        // header count for sector search
        if (i_hdr_match || !i_reading) begin
            n.hdr_cnt = '0;
        end else if (i_hdr_seen) begin
            if (r.hdr_cnt == `FHP_HDR_LIMIT - 6'h01) begin
                n.ev.sect_miss = 1'b1;
                n.hdr_cnt = '0;
            end else begin
                n.hdr_cnt = r.hdr_cnt + 6'h01;
            end
        end

        n.ev.trk_hi = i_seek_start && (i_want_track > `FHP_TRACK_MAX);
        n.ev = n.ev | i_err_ev;

        if (init_rise) begin
            n.flags = '0;
            n.int_en = 1'b0;
            n.ctl_init = 1'b1;
        end

        n.irq = n.int_en && (n.flags != 3'h0);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    fhp_err_hold u_hold (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ev(r.ev),
        .i_clr(r.hold_clr),
        .o_code(hold_code)
    );

    // registered outputs
    assign o_dbus_out = r.dout;
    assign o_dbus_oe = r.dout_oe;
    assign o_internal_io_oe = r.iio;
    assign o_skip_oe = r.skip;
    assign o_service_request_oe = r.irq;
    assign o_transfer_control_a_oe = r.ctl_a;
    assign o_transfer_control_b_oe = r.ctl_b;
    assign o_ifr = r.ifr;
    assign o_ifr_wr = r.ifr_wr;
    assign o_ctl_init = r.ctl_init;
    assign o_int_en = r.int_en;
    assign o_err_code = hold_code;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // sequencer, flag and watchdog checks
    init_clears_a: assert property (init_rise |=> r.flags == 3'h0)
        else $error("initialize left a flag set");
    irq_follows_a: assert property ((r.int_en && i_err_set && !init_rise && !tp3_rise)
        |=> r.irq)
        else $error("service request not raised for enabled flag");
    irq_release_a: assert property ((r.st == FHP_ST_ARMED && r.int_en &&
        r.flags == 3'b001 && pause && tp3_rise && r.op == `FHP_OP_TERR && !i_tr_set &&
        !i_err_set && !i_func_end) |=> !r.irq)
        else $error("service request held after last flag cleared");
    irq_drop_a: assert property ((r.flags == 3'h0) |-> ##1 !r.irq || $past(i_tr_set) ||
        $past(i_err_set) || $past(i_func_end))
        else $error("service request without flag");
    skip_flag_a: assert property ((r.st == FHP_ST_IDLE && hit && md_op == `FHP_OP_TDONE &&
        r.flags.done) |=> r.skip)
        else $error("skip missing for set flag");
    iio_sel_a: assert property ((r.st == FHP_ST_IDLE && hit) |=> r.iio)
        else $error("internal io not grounded when addressed");
    foreign_sel_a: assert property ((r.st == FHP_ST_IDLE && !hit) |=> !r.iio && !r.skip)
        else $error("reacted to another device code");
    test_clears_a: assert property ((r.st == FHP_ST_ARMED && pause && tp3_rise &&
        r.op == `FHP_OP_TTR && !i_tr_set && !init_rise) |=> !r.flags.tr)
        else $error("tested flag not cleared");
    done_result_a: assert property ((i_func_end && i_func != `FHP_FN_RD_ERR && !init_rise)
        |=> r.flags.done && r.ifr == $past(i_error_status_word))
        else $error("done set without status in interface register");
    xfer_drive_a: assert property ((r.st == FHP_ST_IDLE && hit && md_op == `FHP_OP_XFER &&
        i_ctl_dir_out) |=> r.dout_oe && r.ctl_b && r.dout == $past(r.ifr))
        else $error("transfer did not drive the interface register");
    init_pulse_a: assert property (init_rise |=> r.ctl_init && !r.int_en)
        else $error("initialize did not start the controller");
    track_hi_a: assert property ((i_seek_start && i_want_track > `FHP_TRACK_MAX)
        |=> r.ev.trk_hi)
        else $error("track above limit not reported");
    hdr_limit_a: assert property ((i_reading && !i_hdr_match && i_hdr_seen &&
        r.hdr_cnt == `FHP_HDR_LIMIT - 6'h01) |=> r.ev.sect_miss)
        else $error("sector search did not give up at the header limit");
    gap_once_a: assert property ((i_reading && r.gap_cnt == 13'(SEP_GAP_CYC) &&
        !i_err_ev.no_clk) |=> !r.ev.no_clk)
        else $error("bit clock loss reported more than once");
    ifr_write_a: assert property ((r.st == FHP_ST_DONE && pause && tp4_rise &&
        r.op == `FHP_OP_LCMD && !i_xfer_load && !i_func_end)
        |=> r.ifr_wr && r.ifr == $past(r.s2.dbus))
        else $error("host word not clocked into the interface register");
    write_refused_a: assert property ((r.st == FHP_ST_DONE && pause && tp4_rise &&
        r.op == `FHP_OP_XFER && r.dout_oe && !i_xfer_load && !i_func_end)
        |=> !r.ifr_wr && r.ifr == $past(r.ifr))
        else $error("read transfer overwrote the interface register");
    oe_release_a: assert property ((r.st != FHP_ST_IDLE && !pause) |=>
        !r.dout_oe && !r.iio && !r.skip && !r.ctl_b)
        else $error("bus drivers held after the io pause ended");

    cov_xfer_c: cover property (r.dout_oe ##1 !r.dout_oe);
    cov_init_c: cover property (init_rise ##1 r.ctl_init);
    cov_sect_c: cover property (r.ev.sect_miss);
    cov_skip_c: cover property (r.skip && r.st == FHP_ST_DONE);
    cov_nclk_c: cover property (r.ev.no_clk);
endmodule
`default_nettype wire

// *** fhp_cpu_model.sv ***
// processor model on the programmed-io backplane: issues io instructions
// assumes the bench calls iot and resolves the shared data bus itself
`timescale 1ns/100ps
`default_nettype none
module fhp_cpu_model (
    // clock
    input wire logic i_core_clk,
    // from the port
    input wire logic i_skip_oe,
    input wire logic i_internal_io_oe,
    input wire logic i_dbus_oe,
    input wire logic i_ctl_b_oe,
    input wire logic [11:0] i_dbus_out,
    // backplane drive
    output var logic o_io_pause_n,
    output var logic o_tp3,
    output var logic o_tp4,
    output var logic [11:0] o_md,
    output var logic [11:0] o_dbus
);
    initial begin
        o_io_pause_n = 1'b1;
        o_tp3 = 1'b0;
        o_tp4 = 1'b0;
        o_md = 12'h000;
        o_dbus = 12'hFFF;
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // one io instruction; skip, inhibit and read word come back
    task automatic iot(input logic [5:0] dev, input logic [2:0] op, input logic [11:0] ac,
            output logic skp, output logic inh, output logic [11:0] rd);
        o_md = {3'h6, dev, op};
        o_dbus = ac;
        o_io_pause_n = 1'b0;
        step(4);
        skp = i_skip_oe;
        inh = i_internal_io_oe;
        rd = (i_dbus_oe && i_ctl_b_oe) ? i_dbus_out : 12'h000;
        o_tp3 = 1'b1;
        step(1);
        o_tp3 = 1'b0;
        step(2);
        o_tp4 = 1'b1;
        step(1);
        o_tp4 = 1'b0;
        step(2);
        o_io_pause_n = 1'b1;
        o_md = ~o_md;
        o_dbus = ~ac;
        step(5);
    endtask
endmodule
`default_nettype wire

// *** test_fhp_host_port.sv ***
// self-checking bench of the floppy host port with a processor model
// assumes fhp_pkg, fhp_host_port and fhp_cpu_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_fhp_host_port;
    import fhp_pkg::*;
    localparam logic [5:0] DEV = 6'h38;
    localparam logic [11:0] CODES [16] = '{12'h008, 12'h010, 12'h018, 12'h020, 12'h028,
        12'h030, 12'h038, 12'h048, 12'h050, 12'h058, 12'h060, 12'h068, 12'h070, 12'h078,
        12'h000, 12'h088};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic init_pin = 1'b0;
    logic sep_clk = 1'b0;
    logic sep_run = 1'b0;
    int n_init = 0;
    int n_wr = 0;
    int n_ctla = 0;
    logic hdr_match = 1'b0;
    logic ctla;
    logic dir_out = 1'b1;
    logic tr_set = 1'b0;
    logic err_set = 1'b0;
    logic xfer_load = 1'b0;
    logic [11:0] xfer_word = 12'h000;
    logic func_end = 1'b0;
    logic [2:0] func = 3'h0;
    logic [11:0] status = 12'h000;
    fhp_err_ev_type ev = '0;
    logic reading = 1'b0;
    logic hdr_seen = 1'b0;
    logic seek_start = 1'b0;
    logic [6:0] want_track = 7'h00;
    logic pause_n, tp3, tp4, dbus_oe, inh_oe, skip_oe, srq_oe, ctlb, ifr_wr, ctl_init, int_en;
    logic skp, inh;
    logic [11:0] md, cpu_dbus, bus, dbus_out, ifr, err_code, rd;
    fhp_pins_type pins;
    int n_mismatch = 0;
    int n_compared = 0;

    assign bus = dbus_oe ? dbus_out : cpu_dbus;
    assign pins = {pause_n, tp3, tp4, init_pin, sep_clk, md, bus};

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (sep_run) sep_clk <= ~sep_clk;
        if (ctl_init) n_init <= n_init + 1;
        if (ifr_wr) n_wr <= n_wr + 1;
        if (ctla) n_ctla <= n_ctla + 1;
    end

    fhp_host_port #(.SEP_GAP_CYC(20)) dut (.i_core_clk(core_clk), .i_rst(rst),
        .i_pins(pins), .o_dbus_out(dbus_out), .o_dbus_oe(dbus_oe),
        .o_internal_io_oe(inh_oe), .o_skip_oe(skip_oe), .o_service_request_oe(srq_oe),
        .o_transfer_control_a_oe(ctla), .o_transfer_control_b_oe(ctlb), .i_dev_code(DEV),
        .i_ctl_dir_out(dir_out), .i_tr_set(tr_set), .i_err_set(err_set),
        .i_xfer_load(xfer_load), .i_xfer_word(xfer_word), .i_func_end(func_end),
        .i_func(func), .i_error_status_word(status), .i_err_ev(ev), .i_reading(reading),
        .i_hdr_seen(hdr_seen), .i_hdr_match(hdr_match), .i_seek_start(seek_start),
        .i_want_track(want_track), .o_ifr(ifr), .o_ifr_wr(ifr_wr), .o_ctl_init(ctl_init),
        .o_int_en(int_en), .o_err_code(err_code));

    fhp_cpu_model cpu (.i_core_clk(core_clk), .i_skip_oe(skip_oe), .i_internal_io_oe(inh_oe),
        .i_dbus_oe(dbus_oe), .i_ctl_b_oe(ctlb), .i_dbus_out(dbus_out),
        .o_io_pause_n(pause_n), .o_tp3(tp3), .o_tp4(tp4), .o_md(md), .o_dbus(cpu_dbus));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic fend(input logic [2:0] f, input logic [11:0] s);
        func = f;
        status = s;
        func_end = 1'b1;
        tick(1);
        func_end = 1'b0;
        tick(2);
    endtask

    task automatic io(input logic [2:0] op, input logic [11:0] ac);
        cpu.iot(DEV, op, ac, skp, inh, rd);
    endtask

    task automatic seek(input logic [6:0] trk);
        want_track = trk;
        seek_start = 1'b1;
        tick(1);
        seek_start = 1'b0;
        tick(3);
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        tick(16);
        rst = 1'b0;
        tick(3);
        // every error event, then holder read and status read
        for (int i = 0; i < 16; i++) begin
            ev = fhp_err_ev_type'(16'h8000 >> i);
            tick(1);
            ev = '0;
            tick(3);
            chk("err_code", CODES[i], err_code);
            fend(3'h7, 12'h300);
            chk("ifr holder read", CODES[i], ifr);
            fend(3'h5, 12'h200 + 12'(i));
            chk("err after status", 12'h000, err_code);
            chk("ifr status", 12'h200 + 12'(i), ifr);
        end
        // host instructions
        cpu.iot(DEV + 6'h01, 3'h5, 12'h000, skp, inh, rd);
        chk("foreign inhibit", 12'h000, 12'(inh));
        chk("foreign skip", 12'h000, 12'(skp));
        io(3'h5, 12'h000);
        chk("done skip", 12'h001, 12'(skp));
        chk("inhibit", 12'h001, 12'(inh));
        io(3'h5, 12'h000);
        chk("done cleared", 12'h000, 12'(skp));
        io(3'h2, 12'h000);
        chk("xdr read", 12'h20F, rd);
        chk("status masked", 12'h00F, rd & 12'h0FF);
        dir_out = 1'b0;
        io(3'h2, 12'hA5C);
        chk("xdr write", 12'hA5C, ifr);
        chk("xdr write strobe", 12'h001, 12'(n_wr));
        io(3'h1, 12'h0C3);
        chk("load command", 12'h0C3, ifr);
        chk("load strobe", 12'h002, 12'(n_wr));
        dir_out = 1'b1;
        xfer_word = 12'h3C7;
        xfer_load = 1'b1;
        tr_set = 1'b1;
        tick(1);
        xfer_load = 1'b0;
        tr_set = 1'b0;
        tick(2);
        io(3'h3, 12'h000);
        chk("tr skip", 12'h001, 12'(skp));
        io(3'h2, 12'h000);
        chk("xdr loaded word", 12'h3C7, rd);
        chk("no write on read", 12'h002, 12'(n_wr));
        io(3'h3, 12'h000);
        chk("tr cleared", 12'h000, 12'(skp));
        // service request
        io(3'h6, 12'h001);
        err_set = 1'b1;
        tick(1);
        err_set = 1'b0;
        tick(3);
        chk("srq set", 12'h001, 12'(srq_oe));
        io(3'h4, 12'h000);
        chk("err skip", 12'h001, 12'(skp));
        chk("srq released", 12'h000, 12'(srq_oe));
        // bus initialize
        tr_set = 1'b1;
        tick(1);
        tr_set = 1'b0;
        init_pin = 1'b1;
        tick(6);
        init_pin = 1'b0;
        tick(2);
        chk("ctl init", 12'h001, 12'(n_init));
        chk("int_en cleared", 12'h000, 12'(int_en));
        io(3'h3, 12'h000);
        chk("tr after init", 12'h000, 12'(skp));
        io(3'h7, 12'h000);
        chk("init instruction", 12'h002, 12'(n_init));
        // track limit and header count
        seek(7'h4D);
        chk("track 77", 12'h000, err_code);
        seek(7'h4E);
        chk("track 78", 12'h020, err_code);
        fend(3'h5, 12'h000);
        sep_run = 1'b1;
        reading = 1'b1;
        for (int i = 0; i < 83; i++) begin
            if (i == 82) chk("51 headers", 12'h000, err_code);
            hdr_match = (i == 30);
            hdr_seen = (i != 30);
            tick(1);
            hdr_match = 1'b0;
            hdr_seen = 1'b0;
            tick(1);
        end
        tick(2);
        chk("52 headers", 12'h038, err_code);
        fend(3'h5, 12'h000);
        // bit clock watchdog
        sep_run = 1'b0;
        tick(30);
        chk("no bit clock", 12'h048, err_code);
        fend(3'h5, 12'h000);
        tick(30);
        chk("no clock once", 12'h000, err_code);
        reading = 1'b0;
        chk("ctl a idle", 12'h000, 12'(n_ctla));
        give_verdict();
    end
endmodule
`default_nettype wire
